/* File: sla_pkg.sv */
// Constants and types shared by the channel alignment block.
package sla_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned CHAN_MAX = 16;
  localparam int unsigned WORD_BITS = 4;
  localparam int unsigned TAP_BITS = 6;
  localparam logic [4:0] CHAN_DEFAULT = 5'h10;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SETTLE_NS = 160;
  localparam logic [3:0] SETTLE_CYC = 4'((SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000);

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NCHAN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WINDOW = 8'h0C;
  localparam logic [7:0] ADDR_TAP_BASE = 8'h40;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int unsigned ST_LOCKED_LSB = 0;
  localparam int unsigned ST_BUS_BIT = 8;
  localparam int unsigned ST_PHASE_LSB = 9;
  localparam int unsigned ST_SEQ_LSB = 12;
  localparam int unsigned WIN_CENTER_LSB = 8;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_ALIGN = 2'b01,
    SEQ_DONE = 2'b10
  } sla_seq_e;

  typedef enum logic [2:0]
  {
    AL_IDLE = 3'b000,
    AL_SETTLE = 3'b001,
    AL_FIND_RISE = 3'b010,
    AL_MEASURE = 3'b011,
    AL_CENTER = 3'b100,
    AL_DONE = 3'b101
  } sla_align_e;

  typedef struct packed
  {
    logic [3:0] chan;
    logic inc;
    logic dec;
  } sla_delay_ctl_s;

  typedef logic [TAP_BITS-1:0] sla_tap_t;

endpackage

/* File: sla_channel_align.sv */
// Per-channel delay search and single-pass in-order channel sequencer with an Avalon-MM register slave.
//
// Behaviour
// - Each channel arrives as four-bit parallel words, four serial bits per word.
// - Clock-pattern request is raised to start a channel; far end toggles while high.
// - Step the delay up one tap at a time until a 0-to-1 transition.
// - After the opening edge, count each applied tap as window width.
// - Keep stepping and counting until a 1-to-0 transition ends the window.
// - Step back down half the counted width and keep that tap for the channel.
// - Search and centring repeat for every configured channel (the first nchan channels), one after another.
// - Channels are aligned one at a time, from the first upward to the last.
// - On done the locked count rises by one and the selection moves on.
// - In the same cycle as the count update the start output pulses for the new channel.
// - All-aligned is high exactly when locked count equals configured channels, default sixteen.
// - Done at count total minus one still counts and enters the finished state.
// - The sequencer runs on the received clock divided by four, the word clock.
// - Active-high reset clears the count and selects the first channel.
// - The locked-channel count is a five-bit unsigned output.
// - Done rises only after the selected channel finished search and centring.
// - Done and request pair: 00 word, 01 bit alignment, 10 or 11 complete.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
module sla_channel_align
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [sla_pkg::CHAN_MAX*sla_pkg::WORD_BITS-1:0] rx_word_in,
  output sla_pkg::sla_delay_ctl_s input_delay_line_out,
  output logic clock_pattern_req_out,
  output logic data_aligned_out,
  output logic start_channel_align_out,
  output logic [4:0] channels_locked_out,
  output logic bus_aligned_out
);
  import sla_pkg::*;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [3:0] chan_word(input logic [CHAN_MAX*WORD_BITS-1:0] w, input logic [3:0] ch);
    chan_word = w[ch*WORD_BITS +: WORD_BITS];
  endfunction

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic run_q, run_d;
  logic [4:0] nchan_q, nchan_d;
  logic access;

  // Sequencer and alignment state, declared here for the read mux.
  sla_seq_e seq_q, seq_d;
  logic [4:0] locked_q, locked_d;
  logic [3:0] sel_q, sel_d;
  logic start_q, start_d;
  sla_align_e al_q, al_d, ret_q, ret_d;
  logic [3:0] wait_q, wait_d;
  logic prev_q, prev_d, prev_ok_q, prev_ok_d;
  sla_tap_t width_q, width_d, half_q, half_d;
  logic inc_q, inc_d, dec_q, dec_d;
  sla_tap_t tap_q [CHAN_MAX];
  logic [3:0] cur_word;
  logic cur_bit;

  assign access = avs_read_in | avs_write_in;

  // One wait state: the request is taken on the edge where waitrequest is low.
  always_comb
  begin
    ack_d = access & ~ack_q;
    rdata_d = rdata_q;
    run_d = run_q;
    nchan_d = nchan_q;
    if (ack_d && avs_read_in)
    begin
      if (avs_address_in == ADDR_CTRL)
        rdata_d = {31'h00000000, run_q};
      else if (avs_address_in == ADDR_NCHAN)
        rdata_d = {27'h0000000, nchan_q};
      else if (avs_address_in == ADDR_STATUS)
      begin
        rdata_d = UNMAPPED_DATA;
        rdata_d[ST_LOCKED_LSB +: 5] = locked_q;
        rdata_d[ST_BUS_BIT] = bus_aligned_out;
        rdata_d[ST_PHASE_LSB +: 2] = {data_aligned_out, clock_pattern_req_out};
        rdata_d[ST_SEQ_LSB +: 2] = seq_q;
      end
      else if (avs_address_in == ADDR_WINDOW)
      begin
        rdata_d = UNMAPPED_DATA;
        rdata_d[TAP_BITS-1:0] = width_q;
        rdata_d[WIN_CENTER_LSB +: TAP_BITS] = tap_q[sel_q];
      end
      else if (avs_address_in[7:6] == ADDR_TAP_BASE[7:6] && avs_address_in[1:0] == 2'h0)
        rdata_d = {{(32-TAP_BITS){1'b0}}, tap_q[avs_address_in[5:2]]};
      else
        rdata_d = UNMAPPED_DATA;
    end
    if (ack_q && avs_write_in)
    begin
      if (avs_address_in == ADDR_CTRL)
        run_d = avs_writedata_in[CTRL_RUN_BIT];
      else if (avs_address_in == ADDR_NCHAN && avs_writedata_in[4:0] != 5'h00
               && avs_writedata_in[4:0] <= CHAN_DEFAULT)
        nchan_d = avs_writedata_in[4:0];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      ack_q <= 1'b0;
      rdata_q <= UNMAPPED_DATA;
      run_q <= CTRL_RUN_RESET;
      nchan_q <= CHAN_DEFAULT;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      run_q <= run_d;
      nchan_q <= nchan_d;
    end
  end

  assign avs_waitrequest_out = access & ~ack_q;
  assign avs_readdata_out = rdata_q;

  // ---------------------------------------------------------------
  // Channel sequencer
  // ---------------------------------------------------------------
  // Runs on clock_in, which is the word clock: forwarded clock divided by four.
  // Counting is skipped while start is high, because done is still seen during
  // the start pulse and would otherwise be counted twice.
  always_comb
  begin
    seq_d = seq_q;
    locked_d = locked_q;
    sel_d = sel_q;
    start_d = 1'b0;
    unique case (seq_q)
      SEQ_IDLE:
      begin
        if (run_q)
        begin
          seq_d = SEQ_ALIGN;
          start_d = 1'b1;
        end
      end
      SEQ_ALIGN:
      begin
        if (data_aligned_out && !start_q)
        begin
          locked_d = locked_q + 5'h01;
          sel_d = sel_q + 4'h1;
          if (locked_q == nchan_q - 5'h01)
            seq_d = SEQ_DONE;
          else
            start_d = 1'b1;
        end
      end
      SEQ_DONE:
      begin
        seq_d = SEQ_DONE;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      seq_q <= SEQ_IDLE;
      locked_q <= 5'h00;
      sel_q <= 4'h0;
      start_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      locked_q <= locked_d;
      sel_q <= sel_d;
      start_q <= start_d;
    end
  end

  assign start_channel_align_out = start_q;
  assign channels_locked_out = locked_q;
  assign bus_aligned_out = (locked_q == nchan_q);

  // ---------------------------------------------------------------
  // Alignment state machine
  // ---------------------------------------------------------------
  // Bit 0 of the selected channel's four-bit word is watched tap by tap.
  // The tap counter wraps like the delay line; the periodic training pattern
  // always shows another edge, so the search cannot stall.
  assign cur_word = chan_word(rx_word_in, sel_q);
  assign cur_bit = cur_word[0];

  always_comb
  begin
    al_d = al_q;
    ret_d = ret_q;
    wait_d = wait_q;
    prev_d = prev_q;
    prev_ok_d = prev_ok_q;
    width_d = width_q;
    half_d = half_q;
    inc_d = 1'b0;
    dec_d = 1'b0;
    unique case (al_q)
      AL_IDLE, AL_DONE:
      begin
        if (start_q)
        begin
          al_d = AL_SETTLE;
          ret_d = AL_FIND_RISE;
          wait_d = SETTLE_CYC;
          prev_ok_d = 1'b0;
        end
      end
      AL_SETTLE:
      begin
        // Each tap change needs time to reach the parallel words before sampling.
        wait_d = wait_q - 4'h1;
        if (wait_q == 4'h1)
          al_d = ret_q;
      end
      AL_FIND_RISE:
      begin
        prev_d = cur_bit;
        prev_ok_d = 1'b1;
        inc_d = 1'b1;
        al_d = AL_SETTLE;
        wait_d = SETTLE_CYC;
        if (prev_ok_q && !prev_q && cur_bit)
        begin
          width_d = sla_tap_t'(1);
          ret_d = AL_MEASURE;
        end
      end
      AL_MEASURE:
      begin
        prev_d = cur_bit;
        al_d = AL_SETTLE;
        wait_d = SETTLE_CYC;
        if (prev_q && !cur_bit)
        begin
          half_d = width_q >> 1;
          if (width_q >> 1 == sla_tap_t'(0))
            al_d = AL_DONE;
          else
            ret_d = AL_CENTER;
          wait_d = width_q >> 1 == sla_tap_t'(0) ? wait_q : SETTLE_CYC;
        end
        else
        begin
          inc_d = 1'b1;
          width_d = width_q + sla_tap_t'(1);
        end
      end
      AL_CENTER:
      begin
        dec_d = 1'b1;
        half_d = half_q - sla_tap_t'(1);
        if (half_q == sla_tap_t'(1))
          al_d = AL_DONE;
        else
        begin
          al_d = AL_SETTLE;
          wait_d = SETTLE_CYC;
        end
      end
      default:
      begin
        al_d = AL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      al_q <= AL_IDLE;
      ret_q <= AL_FIND_RISE;
      wait_q <= 4'h0;
      prev_q <= 1'b0;
      prev_ok_q <= 1'b0;
      width_q <= '0;
      half_q <= '0;
      inc_q <= 1'b0;
      dec_q <= 1'b0;
    end
    else
    begin
      al_q <= al_d;
      ret_q <= ret_d;
      wait_q <= wait_d;
      prev_q <= prev_d;
      prev_ok_q <= prev_ok_d;
      width_q <= width_d;
      half_q <= half_d;
      inc_q <= inc_d;
      dec_q <= dec_d;
    end
  end

  // The tap kept for each channel follows every step sent to its delay line.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < CHAN_MAX; i++)
        tap_q[i] <= '0;
    end
    else if (inc_d)
      tap_q[sel_q] <= tap_q[sel_q] + sla_tap_t'(1);
    else if (dec_d)
      tap_q[sel_q] <= tap_q[sel_q] - sla_tap_t'(1);
  end

  assign input_delay_line_out = '{chan: sel_q, inc: inc_q, dec: dec_q};
  // Request stays high through the whole search so the far end keeps toggling.
  assign clock_pattern_req_out = (al_q != AL_IDLE) && (al_q != AL_DONE);
  assign data_aligned_out = (al_q == AL_DONE);

endmodule

/* File: sla_channel_align_chk.sv */
// Concurrent checks on the channel alignment block ports.
module sla_channel_align_chk
  import sla_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire sla_pkg::sla_delay_ctl_s input_delay_line_out,
  input wire logic clock_pattern_req_out,
  input wire logic data_aligned_out,
  input wire logic start_channel_align_out,
  input wire logic [4:0] channels_locked_out,
  input wire logic bus_aligned_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // The compare assumes the channel total stays at its reset value.
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  all_aligned_a: assert property (bus_aligned_out == (channels_locked_out == CHAN_DEFAULT))
    else $error("all-aligned flag disagrees with count");
  count_step_a: assert property ($changed(channels_locked_out) |-> channels_locked_out == $past(channels_locked_out) + 5'h01)
    else $error("locked count moved by other than one");
  done_counts_a: assert property ($rose(data_aligned_out) |=> channels_locked_out == $past(channels_locked_out) + 5'h01)
    else $error("done did not advance the count");
  start_follows_a: assert property ($changed(channels_locked_out) && channels_locked_out != 5'h10 |-> start_channel_align_out)
    else $error("start missing after count update");
  final_hold_a: assert property (channels_locked_out == 5'h10 |=> channels_locked_out == 5'h10 && !start_channel_align_out)
    else $error("finished state left");
  start_request_a: assert property (start_channel_align_out |=> clock_pattern_req_out)
    else $error("request not raised after start");
  request_ends_a: assert property ($fell(clock_pattern_req_out) |-> data_aligned_out)
    else $error("request dropped without done");
  tap_spacing_a: assert property (input_delay_line_out.inc |=> !input_delay_line_out.inc [*4])
    else $error("delay steps too close");
  select_order_a: assert property ($changed(input_delay_line_out.chan) |-> input_delay_line_out.chan == $past(input_delay_line_out.chan) + 4'h1)
    else $error("channel selection out of order");
  reset_clear_a: assert property ($fell(sys_rst_in) |-> channels_locked_out == 5'h00 && input_delay_line_out.chan == 4'h0)
    else $error("reset did not clear sequencer");
endmodule

bind sla_channel_align sla_channel_align_chk u_chk
(
  .clock_in(clock_in),
  .sys_rst_in(sys_rst_in),
  .input_delay_line_out(input_delay_line_out),
  .clock_pattern_req_out(clock_pattern_req_out),
  .data_aligned_out(data_aligned_out),
  .start_channel_align_out(start_channel_align_out),
  .channels_locked_out(channels_locked_out),
  .bus_aligned_out(bus_aligned_out)
);

/* File: sla_far_tx.sv */
// Behavioural far transmitter with a per-channel delay line and valid window.
module sla_far_tx
  import sla_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire sla_pkg::sla_delay_ctl_s dly_in,
  input wire logic req_in,
  output logic [63:0] word_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Delay taps
  // ---------------------------------------------------------------
  sla_tap_t tap_q [16];
  logic [3:0] tgl_q;
  always_ff @(posedge clock_in)
  begin
    tgl_q <= sys_rst_in ? 4'h0 : tgl_q + 4'h1;
    for (int n = 0; n < 16; n++)
    begin
      if (sys_rst_in)
        tap_q[n] <= '0;
      else if (dly_in.chan == 4'(n) && dly_in.inc)
        tap_q[n] <= tap_q[n] + 6'h01;
      else if (dly_in.chan == 4'(n) && dly_in.dec)
        tap_q[n] <= tap_q[n] - 6'h01;
    end
  end
  // ---------------------------------------------------------------
  // Line levels
  // ---------------------------------------------------------------
  // Outside training the lines carry a pattern that moves every cycle, so stale data never looks valid.
  always_comb
  begin
    for (int n = 0; n < 16; n++)
    begin
      if (req_in)
        word_out[4*n +: 4] = {3'b101, tap_q[n] >= 6'(2 + n % 4) && tap_q[n] < 6'(8 + n % 4)};
      else
        word_out[4*n +: 4] = tgl_q;
    end
  end
endmodule

/* File: sla_channel_align_tb.sv */
// Self-checking bench for the channel alignment block.
module sla_channel_align_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sla_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [63:0] rx_word;
  sla_delay_ctl_s dly;
  logic req;
  logic [4:0] channels_locked_out;
  logic bus_aligned_out;
  logic [31:0] q;
  int n_fail = 0;
  int tests_run = 0;
  initial
  begin
    forever #20 clock_in = ~clock_in;
  end
  sla_channel_align u_dut
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .rx_word_in(rx_word),
    .input_delay_line_out(dly),
    .clock_pattern_req_out(req),
    .data_aligned_out(),
    .start_channel_align_out(),
    .channels_locked_out(channels_locked_out),
    .bus_aligned_out(bus_aligned_out)
  );
  sla_far_tx u_tx
  (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .dly_in(dly),
    .req_in(req),
    .word_out(rx_word)
  );
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waitrequest is sampled at each rising edge; the edge that sees it low takes the transfer.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= ~w;
    avs_writedata_in <= d;
    do
    begin
      @(posedge clock_in);
      k++;
    end
    while (avs_waitrequest_out !== 1'b0 && k < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (k >= 50)
    begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic wait_locked(input logic [4:0] n);
    int k;
    k = 0;
    while (channels_locked_out !== n && k < 20000)
    begin
      @(negedge clock_in);
      k++;
    end
    if (k >= 20000)
    begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic reset_dut();
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    reset_dut();
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(q & 32'h1, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check(q & 32'h1, 32'h0);
    bus(1'b1, ADDR_NCHAN, 32'h0);
    bus(1'b0, ADDR_NCHAN, 32'h0);
    check(q & 32'h1F, 32'h10);
    bus(1'b0, 8'h20, 32'h0);
    check(q, UNMAPPED_DATA);
    wait_locked(5'h03);
    @(posedge clock_in);
    reset_dut();
    @(negedge clock_in);
    check(32'(channels_locked_out), 32'h0);
    check(32'(bus_aligned_out), 32'h0);
    wait_locked(5'h10);
    repeat (20) @(posedge clock_in);
    check(32'(channels_locked_out), 32'h10);
    check(32'(bus_aligned_out), 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check(q & 32'h3717, 32'h2510);
    bus(1'b0, ADDR_WINDOW, 32'h0);
    check(q & 32'h3F3F, 32'h0506);
    for (int n = 0; n < 16; n++)
    begin
      bus(1'b0, ADDR_TAP_BASE + 8'(4 * n), 32'h0);
      check(q & 32'h3F, 32'(5 + n % 4));
      check(32'(u_tx.tap_q[n]), 32'(5 + n % 4));
    end
    test_done();
  end
endmodule
